// *** hdl/pio_ext_ctrl.sv ***
// Purpose: External-side control of a 32-line pattern input/output port
// Assumes: Host engine supplies write-done and next-data events on i_clk
// Notes:   Pacer clocks are clock ports of their own, sampled on falling edges
//
// Overview of operation
// - Direction chosen per 16-line half.
// - Three setups: all in, split, all out.
// - Same direction logic in both modes.
// - Group A low lines interrupt on rise.
// - Five control signals per pattern direction.
// - Only input acknowledge and output request driven.
// - External pacer captures or drives on falling.
// - Enabled selected begin edge starts transfer.
// - Enabled selected end edge stops transfer.
// - Triggers need 50 ns qualified levels.
// - All request/acknowledge lines active low.
// - Input request needs low over 50 ns.
// - Data before first request is discarded.
// - Write word, then pulse acknowledge low.
// - Drive output request low, then watch acknowledge.
// - Acknowledge low over 100 ns completes word.
`timescale 1ns/1ps

module pio_ext_ctrl
#(
    parameter int DATA_W = 32,
    parameter int QCNT_W = 4
)
(
    // Clocks and reset
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_in_pacer_clock,
    input wire logic i_out_pacer_clock,
    // Configuration
    input wire logic [1:0] i_dir_setup,
    input wire logic i_busmaster_mode,
    input wire logic [3:0] i_irq_enable,
    input wire logic [1:0] i_in_src,
    input wire logic [1:0] i_out_src,
    input wire pio_pkg::pio_trig_s i_in_trig,
    input wire pio_pkg::pio_trig_s i_out_trig,
    input wire logic i_in_timer_tick,
    input wire logic i_out_timer_tick,
    // Data pins, each three signals
    input wire logic [DATA_W-1:0] i_data,
    output logic [DATA_W-1:0] o_data,
    output logic [DATA_W-1:0] o_data_oe,
    // General-purpose access
    input wire logic [DATA_W-1:0] i_gp_out,
    output logic [DATA_W-1:0] o_gp_in,
    output logic [3:0] o_line_irq,
    // Control pins
    input wire logic i_in_trigger_begin,
    input wire logic i_out_trigger_begin,
    input wire logic i_in_trigger_end,
    input wire logic i_out_trigger_end,
    input wire logic i_in_request_n,
    output logic o_in_acknowledge_n,
    output logic o_out_request_n,
    input wire logic i_out_acknowledge_n,
    // Host engine side
    output pio_pkg::pio_word_s o_in_word,
    input wire logic i_in_write_done,
    output logic o_out_next,
    input wire pio_pkg::pio_word_s i_out_word,
    output logic o_in_active,
    output logic o_out_active
);
    // ========================================================
    // Elaboration checks
    // ========================================================
    if (DATA_W != pio_pkg::DATA_W)
    begin : g_bad_width
        $error("Data width must be 32");
    end
    if ((1 << QCNT_W) <= pio_pkg::ACK_CYC)
    begin : g_bad_cnt
        $error("Qualifier counter too narrow");
    end

    // Maps a pin word onto the captured pattern word
    function automatic logic [DATA_W-1:0] in_map(input pio_pkg::pio_setup_e s,
                                                 input logic [DATA_W-1:0] pins);
        return (s == pio_pkg::PIO_SETUP_SPLIT) ?
            {{pio_pkg::HALF_W{1'b0}}, pins[pio_pkg::HALF_W-1:0]} : pins;
    endfunction

    // Maps a pattern word onto the driven pins
    function automatic logic [DATA_W-1:0] out_map(input pio_pkg::pio_setup_e s,
                                                  input logic [DATA_W-1:0] w);
        return (s == pio_pkg::PIO_SETUP_SPLIT) ?
            {w[pio_pkg::HALF_W-1:0], {pio_pkg::HALF_W{1'b0}}} : w;
    endfunction

    // ========================================================
    // Direction decode
    // ========================================================
    // Same decode serves general-purpose and pattern use
    pio_pkg::pio_setup_e setup;
    wire logic half_lo_out;  // Groups A and B drive
    wire logic half_hi_out;  // Groups C and D drive
    wire logic can_in;
    wire logic can_out;
    // Unused code falls back to all input, the safe state
    assign setup = (i_dir_setup == 2'h1) ? pio_pkg::PIO_SETUP_SPLIT :
                   (i_dir_setup == 2'h2) ? pio_pkg::PIO_SETUP_ALL_OUT :
                   pio_pkg::PIO_SETUP_ALL_IN;
    assign half_lo_out = (setup == pio_pkg::PIO_SETUP_ALL_OUT);
    assign half_hi_out = (setup != pio_pkg::PIO_SETUP_ALL_IN);
    assign can_in = (setup != pio_pkg::PIO_SETUP_ALL_OUT);
    assign can_out = (setup != pio_pkg::PIO_SETUP_ALL_IN);
    // Enables per 16-line half
    assign o_data_oe = {{pio_pkg::HALF_W{half_hi_out}}, {pio_pkg::HALF_W{half_lo_out}}};

    pio_pkg::pio_src_e in_src;
    pio_pkg::pio_src_e out_src;
    assign in_src = (i_in_src == 2'h1) ? pio_pkg::PIO_SRC_EXTERNAL :
                    (i_in_src == 2'h2) ? pio_pkg::PIO_SRC_HANDSHAKE : pio_pkg::PIO_SRC_TIMER;
    assign out_src = (i_out_src == 2'h1) ? pio_pkg::PIO_SRC_EXTERNAL :
                     (i_out_src == 2'h2) ? pio_pkg::PIO_SRC_HANDSHAKE : pio_pkg::PIO_SRC_TIMER;

    // ========================================================
    // Synchronisers
    // ========================================================
    logic [pio_pkg::NQ-1:0] q_meta;   // First stage, read only by q_sync
    logic [pio_pkg::NQ-1:0] q_sync;   // Usable control levels
    logic [DATA_W-1:0] d_meta;        // First stage of the data lines
    logic [DATA_W-1:0] d_sync;        // Usable data lines
    wire logic [pio_pkg::NQ-1:0] q_pins;
    assign q_pins = {i_out_acknowledge_n, i_in_request_n, i_out_trigger_end,
                     i_in_trigger_end, i_out_trigger_begin, i_in_trigger_begin};

    // Two flops ahead of any edge or width logic
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            q_meta <= pio_pkg::Q_RST;
            q_sync <= pio_pkg::Q_RST;
            d_meta <= '0;
            d_sync <= '0;
        end
        else
        begin
            q_meta <= q_pins;
            q_sync <= q_meta;
            d_meta <= i_data;
            d_sync <= d_meta;
        end
    end
    assign o_gp_in = d_sync;

    // ========================================================
    // Level qualifiers
    // ========================================================
    // A new level counts only after it has held its least time; short
    // glitches never reach the edge logic, at the cost of fixed latency
    logic [pio_pkg::NQ-1:0] q_lvl;    // Qualified levels
    wire logic [pio_pkg::NQ-1:0] q_chg;  // One-cycle change of qualified level
    for (genvar g = 0; g < pio_pkg::NQ; g++)
    begin : g_qual
        localparam logic [QCNT_W-1:0] THR = QCNT_W'(
            (g == pio_pkg::Q_OUT_ACK) ? pio_pkg::ACK_CYC - 1 :
            (g == pio_pkg::Q_IN_REQ) ? pio_pkg::REQ_CYC - 1 : pio_pkg::TRIG_CYC - 1);
        logic [QCNT_W-1:0] cnt;  // Cycles the raw level has differed
        assign q_chg[g] = (q_sync[g] != q_lvl[g]) && (cnt == THR);
        // Width qualification
        always_ff @(posedge i_clk or posedge i_rst)
        begin
            if (i_rst)
            begin
                cnt <= '0;
                q_lvl[g] <= pio_pkg::Q_RST[g];
            end
            else if (q_sync[g] == q_lvl[g])
            begin
                cnt <= '0;
            end
            else if (q_chg[g])
            begin
                cnt <= '0;
                q_lvl[g] <= q_sync[g];
            end
            else
            begin
                cnt <= cnt + 1'b1;
            end
        end
    end

    // Rising or falling edge as software selects
    function automatic logic trig_hit(input logic en, input logic rise,
                                      input logic chg, input logic lvl_now);
        return en && chg && (rise ? !lvl_now : lvl_now);
    endfunction

    wire logic in_begin_hit;
    wire logic in_end_hit;
    wire logic out_begin_hit;
    wire logic out_end_hit;
    wire logic req_seen;  // Qualified low pulse on input request
    wire logic ack_seen;  // Qualified low pulse on output acknowledge
    assign in_begin_hit = trig_hit(i_in_trig.begin_en, i_in_trig.begin_rise,
        q_chg[pio_pkg::Q_IN_BEGIN], q_lvl[pio_pkg::Q_IN_BEGIN]);
    assign out_begin_hit = trig_hit(i_out_trig.begin_en, i_out_trig.begin_rise,
        q_chg[pio_pkg::Q_OUT_BEGIN], q_lvl[pio_pkg::Q_OUT_BEGIN]);
    assign in_end_hit = trig_hit(i_in_trig.end_en, i_in_trig.end_rise,
        q_chg[pio_pkg::Q_IN_END], q_lvl[pio_pkg::Q_IN_END]);
    assign out_end_hit = trig_hit(i_out_trig.end_en, i_out_trig.end_rise,
        q_chg[pio_pkg::Q_OUT_END], q_lvl[pio_pkg::Q_OUT_END]);
    // Active-low handshake inputs: falling of qualified level
    assign req_seen = q_chg[pio_pkg::Q_IN_REQ] && q_lvl[pio_pkg::Q_IN_REQ];
    assign ack_seen = q_chg[pio_pkg::Q_OUT_ACK] && q_lvl[pio_pkg::Q_OUT_ACK];

    // ========================================================
    // Run flags
    // ========================================================
    // End wins when both land in one cycle, so a stop is never missed
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_in_active <= 1'b0;
            o_out_active <= 1'b0;
        end
        else
        begin
            o_in_active <= can_in && !in_end_hit && (o_in_active || in_begin_hit);
            o_out_active <= can_out && !out_end_hit && (o_out_active || out_begin_hit);
        end
    end

    // ========================================================
    // Line interrupts
    // ========================================================
    logic [3:0] irq_prev;  // Last synced level of the four lines
    wire logic irq_ok;
    // General-purpose mode with group A as input only
    assign irq_ok = !i_busmaster_mode && (setup != pio_pkg::PIO_SETUP_ALL_OUT);
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            irq_prev <= 4'h0;
            o_line_irq <= 4'h0;
        end
        else
        begin
            irq_prev <= d_sync[pio_pkg::IRQ_N-1:0];
            o_line_irq <= irq_ok ? (d_sync[3:0] & ~irq_prev & i_irq_enable) : 4'h0;
        end
    end

    // ========================================================
    // Input pacer domain
    // ========================================================
    logic in_run_meta;  // First stage, run flag into pacer domain
    logic in_run_lk;    // Run flag as seen by the pacer domain
    logic [DATA_W-1:0] in_cap_lk;  // Word caught on the falling edge
    logic in_tog_lk;    // Flips once per captured word
    // Capture on each falling pacer edge
    always_ff @(negedge i_in_pacer_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            in_run_meta <= 1'b0;
            in_run_lk <= 1'b0;
            in_cap_lk <= '0;
            in_tog_lk <= 1'b0;
        end
        else
        begin
            in_run_meta <= o_in_active && (in_src == pio_pkg::PIO_SRC_EXTERNAL);
            in_run_lk <= in_run_meta;
            if (in_run_lk)
            begin
                in_cap_lk <= in_map(setup, i_data);
                in_tog_lk <= !in_tog_lk;
            end
        end
    end

    // Toggle back into the system domain
    logic [2:0] in_tog_s;  // Stage 0 read only by stage 1
    wire logic in_ext_evt;
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            in_tog_s <= 3'h0;
        end
        else
        begin
            in_tog_s <= {in_tog_s[1:0], in_tog_lk};
        end
    end
    // Captured word is stable for a pacer period, longer than this path
    assign in_ext_evt = in_tog_s[2] ^ in_tog_s[1];

    // ========================================================
    // Pattern input and its handshake
    // ========================================================
    typedef enum logic [1:0] {PIO_IH_WAIT, PIO_IH_WRITE, PIO_IH_ACK} pio_ih_e;
    pio_ih_e ih_state;
    logic [QCNT_W-1:0] ack_cnt;  // Length of our acknowledge pulse
    wire logic ih_mode;
    wire logic ih_take;  // Handshake captures a word
    assign ih_mode = o_in_active && (in_src == pio_pkg::PIO_SRC_HANDSHAKE);
    // Only a qualified request captures; earlier data never leaves
    assign ih_take = ih_mode && (ih_state == PIO_IH_WAIT) && req_seen;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ih_state <= PIO_IH_WAIT;
            ack_cnt <= '0;
            o_in_acknowledge_n <= 1'b1;
            o_in_word <= '0;
        end
        else
        begin
            o_in_word.valid <= 1'b0;
            unique case (ih_state)
                PIO_IH_WAIT:
                begin
                    if (ih_take)
                    begin
                        // Hand the word to the bus master
                        o_in_word <= '{valid: 1'b1, data: in_map(setup, d_sync)};
                        ih_state <= PIO_IH_WRITE;
                    end
                    else if (in_ext_evt && o_in_active)
                    begin
                        o_in_word <= '{valid: 1'b1, data: in_cap_lk};
                    end
                    else if (i_in_timer_tick && o_in_active && in_src == pio_pkg::PIO_SRC_TIMER)
                    begin
                        o_in_word <= '{valid: 1'b1, data: in_map(setup, d_sync)};
                    end
                end
                PIO_IH_WRITE:
                begin
                    // Acknowledge only once the host write is done
                    if (i_in_write_done)
                    begin
                        o_in_acknowledge_n <= 1'b0;
                        ack_cnt <= '0;
                        ih_state <= PIO_IH_ACK;
                    end
                end
                PIO_IH_ACK:
                begin
                    // Low for the least pulse time, then back to waiting
                    if (ack_cnt == QCNT_W'(pio_pkg::ACK_OUT_CYC - 1))
                    begin
                        o_in_acknowledge_n <= 1'b1;
                        ih_state <= PIO_IH_WAIT;
                    end
                    else
                    begin
                        ack_cnt <= ack_cnt + 1'b1;
                    end
                end
            endcase
        end
    end

    // ========================================================
    // Pattern output staging
    // ========================================================
    typedef enum logic [1:0] {PIO_OH_IDLE, PIO_OH_OFFER} pio_oh_e;
    pio_oh_e oh_state;
    logic [DATA_W-1:0] stage;  // Next word to drive
    logic staged;              // Stage holds a word
    logic fetch_pend;          // Next-data asked, not yet answered
    logic [DATA_W-1:0] pin_sys;  // Pins in timer, handshake and general use
    wire logic out_ext_evt;
    wire logic oh_mode;
    wire logic consume;  // Stage has been used
    assign oh_mode = o_out_active && (out_src == pio_pkg::PIO_SRC_HANDSHAKE);
    // Ask the engine whenever the stage runs empty while output is active
    assign o_out_next = o_out_active && !staged && !fetch_pend;
    assign consume = staged && o_out_active && (
        (out_src == pio_pkg::PIO_SRC_TIMER && i_out_timer_tick) ||
        (out_src == pio_pkg::PIO_SRC_EXTERNAL && out_ext_evt) ||
        (oh_mode && oh_state == PIO_OH_OFFER && ack_seen));

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            stage <= '0;
            staged <= 1'b0;
            fetch_pend <= 1'b0;
        end
        else
        begin
            if (o_out_next)
            begin
                fetch_pend <= 1'b1;
            end
            else if (i_out_word.valid || !o_out_active)
            begin
                fetch_pend <= 1'b0;
            end
            // Fresh word wins over a consume in the same cycle
            if (i_out_word.valid && fetch_pend)
            begin
                stage <= i_out_word.data;
                staged <= 1'b1;
            end
            else if (consume || !o_out_active)
            begin
                staged <= 1'b0;
            end
        end
    end

    // Output handshake: request low while a word is offered
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            oh_state <= PIO_OH_IDLE;
            o_out_request_n <= 1'b1;
            pin_sys <= '0;
        end
        else
        begin
            if (!o_out_active)
            begin
                pin_sys <= i_gp_out;
            end
            else if (consume && out_src == pio_pkg::PIO_SRC_TIMER)
            begin
                pin_sys <= out_map(setup, stage);
            end
            unique case (oh_state)
                PIO_OH_IDLE:
                begin
                    if (oh_mode && staged)
                    begin
                        pin_sys <= out_map(setup, stage);
                        o_out_request_n <= 1'b0;
                        oh_state <= PIO_OH_OFFER;
                    end
                end
                PIO_OH_OFFER:
                begin
                    // Qualified acknowledge ends the word, fetch begins
                    if (ack_seen || !oh_mode)
                    begin
                        o_out_request_n <= 1'b1;
                        oh_state <= PIO_OH_IDLE;
                    end
                end
            endcase
        end
    end

    // ========================================================
    // Output pacer domain
    // ========================================================
    logic out_run_meta;  // First stage, run flag into pacer domain
    logic out_run_lk;    // Run flag as seen by the pacer domain
    logic [DATA_W-1:0] pin_lk;  // Pins driven from the falling edge
    logic out_tog_lk;    // Flips once per driven word
    // Drive on each falling pacer edge; stage is stable while staged
    always_ff @(negedge i_out_pacer_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            out_run_meta <= 1'b0;
            out_run_lk <= 1'b0;
            pin_lk <= '0;
            out_tog_lk <= 1'b0;
        end
        else
        begin
            out_run_meta <= o_out_active && (out_src == pio_pkg::PIO_SRC_EXTERNAL);
            out_run_lk <= out_run_meta;
            if (out_run_lk)
            begin
                pin_lk <= out_map(setup, stage);
                out_tog_lk <= !out_tog_lk;
            end
        end
    end

    logic [2:0] out_tog_s;  // Stage 0 read only by stage 1
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            out_tog_s <= 3'h0;
        end
        else
        begin
            out_tog_s <= {out_tog_s[1:0], out_tog_lk};
        end
    end
    assign out_ext_evt = out_tog_s[2] ^ out_tog_s[1];

    // Pin source follows the static clock selection
    assign o_data = (o_out_active && out_src == pio_pkg::PIO_SRC_EXTERNAL) ? pin_lk : pin_sys;
endmodule

// *** pkg/pio_pkg.sv ***
// Purpose: Shared constants, types and timing figures for the pattern I/O control block
// Assumes: System clock of 50 MHz; all times in nanoseconds
// Notes:   Cycle counts are derived from the times, rounded up for least times
package pio_pkg;
    // ========================================================
    // Clock and timing
    // ========================================================
    localparam int CLK_MHZ = 50;         // System clock rate
    localparam int PACER_MAX_MHZ = 10;   // Highest pacer clock the far side may send
    localparam int TRIG_MIN_NS = 50;     // Least high and low time of begin/end triggers
    localparam int REQ_MIN_NS = 50;      // Least low pulse on input request
    localparam int ACK_MIN_NS = 100;     // Least low pulse on output acknowledge
    localparam int ACK_OUT_NS = 50;      // Low time of our own input acknowledge

    // Least time to whole cycles, never below one
    function automatic int min_cycles(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int TRIG_CYC = min_cycles(TRIG_MIN_NS);
    localparam int REQ_CYC = min_cycles(REQ_MIN_NS);
    localparam int ACK_CYC = min_cycles(ACK_MIN_NS);
    localparam int ACK_OUT_CYC = min_cycles(ACK_OUT_NS);

    // ========================================================
    // Pin groups and qualifier slots
    // ========================================================
    localparam int DATA_W = 32;          // Four byte groups
    localparam int HALF_W = 16;          // Direction granule
    localparam int IRQ_N = 4;            // Lowest lines of group A
    localparam int NQ = 6;               // Qualified control inputs
    localparam int Q_IN_BEGIN = 0;
    localparam int Q_OUT_BEGIN = 1;
    localparam int Q_IN_END = 2;
    localparam int Q_OUT_END = 3;
    localparam int Q_IN_REQ = 4;
    localparam int Q_OUT_ACK = 5;
    localparam logic [NQ-1:0] Q_RST = 6'h30;  // Handshake lines idle high

    // ========================================================
    // Types
    // ========================================================
    typedef enum logic [1:0] {PIO_SETUP_ALL_IN, PIO_SETUP_SPLIT, PIO_SETUP_ALL_OUT} pio_setup_e;
    typedef enum logic [1:0] {PIO_SRC_TIMER, PIO_SRC_EXTERNAL, PIO_SRC_HANDSHAKE} pio_src_e;

    typedef struct packed
    {
        logic valid;
        logic [DATA_W-1:0] data;
    } pio_word_s;

    typedef struct packed
    {
        logic begin_en;    // Begin edge enabled
        logic begin_rise;  // 1 rising, 0 falling
        logic end_en;      // End edge enabled
        logic end_rise;    // 1 rising, 0 falling
    } pio_trig_s;
endpackage

// *** test/pio_ext_ctrl_checker.sv ***
// Purpose: Port timing checks for pio_ext_ctrl
// Assumes: 50 MHz i_clk, package cycle counts
// Notes:   Attached by the bind at the foot
`timescale 1ns/1ps
module pio_ext_ctrl_checker #(parameter int DATA_W = 32)
(
    // Watched ports
    input wire logic i_clk, i_rst, i_busmaster_mode, i_in_write_done, i_out_acknowledge_n,
    input wire logic o_in_acknowledge_n, o_out_request_n, o_out_active,
    input wire logic [1:0] i_dir_setup,
    input wire logic [3:0] i_irq_enable, o_line_irq,
    input wire logic [DATA_W-1:0] o_data_oe,
    input wire pio_pkg::pio_word_s o_in_word
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_oe; o_data_oe == (i_dir_setup == 2'h2 ? 32'hFFFFFFFF
        : i_dir_setup == 2'h1 ? 32'hFFFF0000 : 32'h0); endproperty
    a_oe: assert property (p_oe) else $error("oe");
    property p_im; o_line_irq != 4'h0 |-> !$past(i_busmaster_mode); endproperty
    a_im: assert property (p_im) else $error("irq mode");
    property p_ie; (o_line_irq & ~$past(i_irq_enable)) == 4'h0; endproperty
    a_ie: assert property (p_ie) else $error("irq mask");
    property p_aw; $fell(o_in_acknowledge_n) |-> $past(i_in_write_done); endproperty
    a_aw: assert property (p_aw) else $error("ack cause");
    property p_al; $fell(o_in_acknowledge_n) |-> !o_in_acknowledge_n [*3] ##1 o_in_acknowledge_n;
    endproperty
    a_al: assert property (p_al) else $error("ack width");
    property p_rq; $fell(o_out_request_n) |-> o_out_active; endproperty
    a_rq: assert property (p_rq) else $error("req idle");
    property p_ra; $rose(o_out_request_n) && o_out_active
        |-> !$past(i_out_acknowledge_n, 3) && !$past(i_out_acknowledge_n, 7); endproperty
    a_ra: assert property (p_ra) else $error("req release");
    property p_v1; o_in_word.valid |=> !o_in_word.valid; endproperty
    a_v1: assert property (p_v1) else $error("word pulse");
    // Main scenarios reached
    c_v: cover property (o_in_word.valid);
    c_a: cover property ($fell(o_in_acknowledge_n));
    c_r: cover property ($rose(o_out_request_n));
endmodule
bind pio_ext_ctrl pio_ext_ctrl_checker #(.DATA_W(DATA_W)) i_chk (.*);

// *** test/pio_far_model.sv ***
// Purpose: Far-side device on the pattern connector
// Assumes: Bench raises go and pace strobes
// Notes:   Pacer stands high outside frames
`timescale 1ns/1ps
module pio_far_model
(
    // Bench strobes and design output
    input wire logic i_req_go, i_pace_en, i_out_request_n,
    // Pins toward the design
    output logic o_in_request_n = 1'h1, o_out_acknowledge_n = 1'h1, o_pacer = 1'h1
);
    // Request low 100 ns, twice the least width
    always @(posedge i_req_go)
    begin
        #10 o_in_request_n = 1'h0;
        #100 o_in_request_n = 1'h1;
    end
    // Slow answer, then acknowledge low 140 ns
    always @(negedge i_out_request_n)
    begin
        #210 o_out_acknowledge_n = 1'h0;
        #140 o_out_acknowledge_n = 1'h1;
    end
    // 120 ns period keeps the pacer under 10 MHz
    always @(posedge i_pace_en)
        while (i_pace_en) begin #55 o_pacer = 1'h0; #65 o_pacer = 1'h1; end
endmodule

// *** test/pio_ext_ctrl_tb_top.sv ***
// Purpose: Directed bench for pio_ext_ctrl
// Assumes: Inputs change by NBA on rising i_clk
// Notes:   Timer ticks and trigger edge setup tied
`timescale 1ns/1ps
`define CK(n, e, a) begin checked++; if ((a) !== (e)) begin fails++; \
    $display("[ERR] %s exp %h got %h", n, e, a); end end
module pio_ext_ctrl_tb_top;
    logic i_clk = '0, i_rst = '0, bm = '1, wd = '0, go = '0, pace = '0;
    logic [1:0] dir = '0, isrc = '0, osrc = '0;
    logic [3:0] ien = '0, tr = '0, o_line_irq;
    logic [31:0] din = '0, gpi, o_data, o_data_oe, oet [3] = '{32'h0, 32'hFFFF0000, 32'hFFFFFFFF};
    logic o_in_acknowledge_n, o_out_request_n, o_out_next, o_in_active, o_out_active;
    pio_pkg::pio_word_s ow = '0, o_in_word;
    wire logic req_n, ack_n, pcl;
    int fails = 0, checked = 0, cyc = 0;
    pio_ext_ctrl i_dut (.i_clk, .i_rst, .i_in_pacer_clock(pcl), .i_out_pacer_clock(pcl),
        .i_dir_setup(dir), .i_busmaster_mode(bm), .i_irq_enable(ien), .i_in_src(isrc),
        .i_out_src(osrc), .i_in_trig(4'hF), .i_out_trig(4'hA), .i_in_timer_tick(1'h0),
        .i_out_timer_tick(1'h0), .i_data(din), .o_data, .o_data_oe, .i_gp_out(32'h0),
        .o_gp_in(gpi), .o_line_irq, .i_in_trigger_begin(tr[0]), .i_in_trigger_end(tr[1]),
        .i_out_trigger_begin(tr[2]), .i_out_trigger_end(tr[3]), .i_in_request_n(req_n),
        .o_in_acknowledge_n, .o_out_request_n, .i_out_acknowledge_n(ack_n), .o_in_word,
        .i_in_write_done(wd), .o_out_next, .i_out_word(ow), .o_in_active, .o_out_active);
    pio_far_model i_far (.i_req_go(go), .i_pace_en(pace), .i_out_request_n(o_out_request_n),
        .o_in_request_n(req_n), .o_out_acknowledge_n(ack_n), .o_pacer(pcl));
    initial forever #10 i_clk = ~i_clk;
    always @(posedge i_clk) if (++cyc == 20000) begin fails++; end_of_test(); end
    task automatic tick(int n); repeat (n) @(posedge i_clk); endtask
    // Condition picker for bounded waits
    function automatic logic sg(int k);
        case (k) 0: return o_in_active; 1: return !o_in_active; 2: return o_in_word.valid;
            3: return !o_in_acknowledge_n; 4: return o_out_active; 5: return !o_out_active;
            6: return o_out_next; 7: return !o_out_request_n; 8: return o_out_request_n;
            default: return |o_line_irq; endcase
    endfunction
    task automatic wt(int k); int n = 0; do @(posedge i_clk); while (sg(k) !== 1'h1 && ++n < 500);
        if (n >= 500) fails++; endtask
    // Trigger held 100 ns each level
    task automatic trg(int k); tr[k] <= 1'h1; tick(5); tr[k] <= 1'h0; tick(5); endtask
    task end_of_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        i_rst <= 1'h1; tick(8); i_rst <= 1'h0; tick(2);
        foreach (oet[s]) for (int b = 0; b < 2; b++) begin dir <= 2'(s); bm <= 1'(b); tick(2);
            `CK("oe", oet[s], o_data_oe) end
        $display("test setup done");
        bm <= 1'h0; dir <= 2'h0; ien <= 4'h1; tick(4); din <= 32'h3; wt(9);
        `CK("irq", 4'h1, o_line_irq) `CK("gp in", 32'h3, gpi)
        bm <= 1'h1; isrc <= 2'h2; $display("test irq done");
        din <= 32'hA5A50001; trg(0); wt(0); din <= 32'h1234ABCD; go <= 1'h1; wt(2);
        `CK("hs word", 32'h1234ABCD, o_in_word.data)
        go <= 1'h0; wd <= 1'h1; tick(1); wd <= 1'h0; wt(3); trg(1); wt(1);
        `CK("hs ack", 1'h1, o_in_acknowledge_n)
        isrc <= 2'h1; din <= 32'h0F0F5A5A; trg(0); wt(0); pace <= 1'h1; wt(2);
        `CK("pacer word", 32'h0F0F5A5A, o_in_word.data)
        pace <= 1'h0; trg(1); wt(1); $display("test input done");
        dir <= 2'h2; osrc <= 2'h2; trg(2); wt(4); ow <= {1'h1, 32'hC3C39696}; tick(1);
        ow <= '0; wt(7); `CK("out data", 32'hC3C39696, o_data)
        wt(8); `CK("next", 1'h1, o_out_next)
        trg(3); wt(5); `CK("req idle", 1'h1, o_out_request_n)
        $display("test output done");
        end_of_test();
    end
endmodule
